/* design/xram_external_move_instr_access_decode.sv */
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
module xram_external_move_instr_access_decode (
  // Clock and reset.
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // Special function register port.
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // Pins sampled by the block.
  input wire logic external_access_pin_in,
  input wire logic boot_select_pin_in,
  input wire logic hw_powerdown_pin_in,
  // External move request from the core.
  input wire logic external_move_instr_req_in,
  input wire logic external_move_instr_write_in,
  input wire logic external_move_instr_ri_in,
  input wire logic [15:0] pointer16_in,
  input wire logic [7:0] ri_low_in,
  // Code fetch request from the core.
  input wire logic fetch_req_in,
  input wire logic [15:0] fetch_addr_in,
  // Routing decision.
  output logic [15:0] external_move_instr_addr_out,
  output logic use_xram_out,
  output logic port0_bus_out,
  output logic port2_bus_out,
  output logic rd_strobe_out,
  output logic wr_strobe_out,
  output logic flash_read_out,
  output logic flash_write_strobe_out,
  output logic code_strobe_out,
  output logic alt_code_strobe_out,
  output logic fetch_boot_rom_out,
  output logic fetch_xram_out,
  output logic [1:0] chipmode_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers.
  // System control bits that steer the external move decode.
  logic xram_disable_bit_ff;
  logic xram_visible_bit_ff;
  // The remaining system control bits are only stored and read back here.
  logic [7:0] sys_other_ff;
  // Page register for the 8-bit indirect moves.
  logic [7:0] xram_page_reg_ff;
  // Chipmode state: the swap bit is written by software, the boot flag by
  // the pin at reset release or on a rising edge of the power-down pin.
  logic swap_bit_ff;
  logic boot_mode_flag_ff;
  // Helpers for the boot flag capture.
  logic rst_seen_ff;
  logic pd_prev_ff;
  // Read path.
  logic [7:0] nxt_rdata;
  logic [7:0] rdata_ff;

  // Write decode, one wire per register.
  wire wr_sys = reg_wr_in && (reg_addr_in == xram_decode_pkg::SYSTEM_CONTROL_REG_ADDR);
  wire wr_mode = reg_wr_in && (reg_addr_in == xram_decode_pkg::CHIPMODE_ADDR);
  wire wr_page = reg_wr_in && (reg_addr_in == xram_decode_pkg::XRAM_PAGE_REG_REG_ADDR);

  // Read-back images of the system control and chipmode registers.
  wire [7:0] sys_read = {sys_other_ff[7:2], xram_visible_bit_ff, xram_disable_bit_ff};
  wire [7:0] mode_read = {6'h00, boot_mode_flag_ff, swap_bit_ff};

  // Read mux; unmapped addresses read as zero. Nothing here has a read side
  // effect, so the mux may look at the address every cycle and only the
  // strobe decides when the result is kept.
  always_comb begin
    nxt_rdata = 8'h00;
    if (reg_addr_in == xram_decode_pkg::SYSTEM_CONTROL_REG_ADDR) begin
      nxt_rdata = sys_read;
    end else if (reg_addr_in == xram_decode_pkg::CHIPMODE_ADDR) begin
      nxt_rdata = mode_read;
    end else if (reg_addr_in == xram_decode_pkg::XRAM_PAGE_REG_REG_ADDR) begin
      nxt_rdata = xram_page_reg_ff;
    end
  end

  // The disable bit only ever clears by software; a 1 written later is dropped
  // so that code loaded into XRAM cannot be unmapped under its own feet.
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      xram_disable_bit_ff <= xram_decode_pkg::SYSTEM_CONTROL_REG_RESET[xram_decode_pkg::XRAM_DIS_POS];
      xram_visible_bit_ff <= xram_decode_pkg::SYSTEM_CONTROL_REG_RESET[xram_decode_pkg::XRAM_VIS_POS];
      sys_other_ff <= xram_decode_pkg::SYSTEM_CONTROL_REG_RESET;
    end else if (wr_sys) begin
      xram_disable_bit_ff <= xram_disable_bit_ff
                             & reg_wdata_in[xram_decode_pkg::XRAM_DIS_POS];
      xram_visible_bit_ff <= reg_wdata_in[xram_decode_pkg::XRAM_VIS_POS];
      sys_other_ff <= {reg_wdata_in[7:6], 1'b1, reg_wdata_in[4], 4'h0};
    end
  end

  // Page register and swap bit. Neither has any protection: software may move
  // the page or swap the code and data spaces at any time, between two
  // external moves.
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      xram_page_reg_ff <= xram_decode_pkg::XRAM_PAGE_REG_RESET;
      swap_bit_ff <= 1'b0;
    end else begin
      if (wr_page) begin
        xram_page_reg_ff <= reg_wdata_in;
      end
      if (wr_mode) begin
        swap_bit_ff <= reg_wdata_in[xram_decode_pkg::SWAP_POS];
      end
    end
  end

  // Read data register, valid the cycle after the strobe.
  // The value holds until the next read so a slow reader still sees it.
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd_in) begin
      rdata_ff <= nxt_rdata;
    end
  end
  assign reg_rdata_out = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Boot flag: the pin is caught on the first clock after reset release or on
  // the rising edge of the power-down pin, never under the reset itself.
  // The flag is read only to software; a write to the chipmode register
  // cannot change it. A pin that moves in the cycle of capture is taken as
  // it stands at that edge.
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      rst_seen_ff <= 1'b0;
      pd_prev_ff <= 1'b0;
      boot_mode_flag_ff <= 1'b0;
    end else begin
      rst_seen_ff <= 1'b1;
      pd_prev_ff <= hw_powerdown_pin_in;
      if (!rst_seen_ff || (hw_powerdown_pin_in && !pd_prev_ff)) begin
        boot_mode_flag_ff <= boot_select_pin_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Chipmode decode. The boot flag is the upper bit and the swap bit the
  // lower one, so the four codes follow the package encoding directly.
  wire [1:0] mode_bits = {boot_mode_flag_ff, swap_bit_ff};
  wire mode_xram = (mode_bits == xram_decode_pkg::MODE_XRAM);
  wire mode_prog = (mode_bits == xram_decode_pkg::MODE_PROG);

  // In both swapped modes the code and data spaces trade places, so the data
  // strobes move to the flash pins and XRAM becomes code memory.
  wire swapped = mode_xram || mode_prog;

  // The boot ROM shadows the bottom of code space in every mode but normal.
  wire boot_rom_on = (mode_bits != xram_decode_pkg::MODE_NORMAL);

  // Software sees the selected mode as a two-bit code.
  assign chipmode_out = mode_bits;

  ////////////////////////////////////////////////////////////////////////////
  // External move decode. Only external-move requests reach XRAM as data; fetches reach it in swapped modes.
  // An indirect move takes its high byte from the page register, so the range
  // test for it looks at the page alone.
  wire [15:0] eff_addr = external_move_instr_ri_in ? {xram_page_reg_ff, ri_low_in} : pointer16_in;
  wire in_range = external_move_instr_ri_in ? (xram_page_reg_ff >= xram_decode_pkg::XRAM_PAGE_BASE)
                             : (pointer16_in >= xram_decode_pkg::XRAM_BASE);
  // In swapped modes the data space is all external flash or ROM.
  wire hit_xram = external_move_instr_req_in && in_range && !xram_disable_bit_ff && !swapped;
  // The visible bit only matters on an XRAM hit; elsewhere it is ignored.
  wire visible = hit_xram && xram_visible_bit_ff;
  wire ext_access = external_move_instr_req_in && !hit_xram;
  // Strobes run for every external access and for visible XRAM accesses.
  wire strobe_on = ext_access || visible;
  // Non-visible XRAM with the pin low still drives the data onto the bus.
  wire hidden_bus = hit_xram && !xram_visible_bit_ff && !external_access_pin_in;
  // XRAM chipmode treats the external data space as read only.
  wire wr_allowed = !mode_xram;
  // Read and write events before they are steered to a strobe pin.
  wire rd_ev = strobe_on && !external_move_instr_write_in;
  wire wr_ev = strobe_on && external_move_instr_write_in && wr_allowed;

  // Port 2 carries the high address only for pointer moves.
  assign external_move_instr_addr_out = eff_addr;
  assign use_xram_out = hit_xram;
  assign port0_bus_out = strobe_on || hidden_bus;
  assign port2_bus_out = !external_move_instr_ri_in && (strobe_on || hidden_bus);
  // Swapped modes move data strobes to the flash pins.
  assign rd_strobe_out = rd_ev && !swapped;
  assign wr_strobe_out = wr_ev && !swapped;
  assign flash_read_out = rd_ev && swapped;
  assign flash_write_strobe_out = wr_ev && mode_prog;

  ////////////////////////////////////////////////////////////////////////////
  // Code fetch decode: the boot ROM shadows everything below 0200.
  // A fetch that is neither boot ROM nor XRAM goes out on a code strobe; which
  // strobe depends on whether the spaces are swapped.
  wire fetch_low = fetch_addr_in < xram_decode_pkg::EXT_CODE_BASE;
  wire fetch_rom = fetch_req_in && boot_rom_on && fetch_low;
  // Swapped modes map XRAM into code space at its usual addresses.
  wire fetch_x = fetch_req_in && swapped && !fetch_rom
                 && (fetch_addr_in >= xram_decode_pkg::XRAM_BASE);
  wire fetch_ext = fetch_req_in && !fetch_rom && !fetch_x;
  // The fetch routing leaves the block as plain flags.
  assign fetch_boot_rom_out = fetch_rom;
  assign fetch_xram_out = fetch_x;
  assign code_strobe_out = fetch_ext && !swapped;
  assign alt_code_strobe_out = fetch_ext && swapped;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  // Each property watches what the decode drives, one clock at a time. The
  // decode is combinational, so most checks compare outputs in the same cycle
  // as the request that causes them, except where a register is involved.
  // Reset gates every check but a_disable_reset and a_boot_capture, which only fire at its release, so the cycles under reset raise nothing.

  // Reset must leave the XRAM switched off.
  a_disable_reset: assert property (@(posedge core_clk_in)
    $rose(rst_n_in) |-> xram_disable_bit_ff)
    else $error("disable bit not set after reset");

  // Once cleared, only a reset sets the disable bit again.
  a_disable_sticky: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !xram_disable_bit_ff |=> !xram_disable_bit_ff)
    else $error("disable bit set by software");

  // Hidden XRAM accesses stay off the external strobes.
  a_hidden_quiet: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (hit_xram && !xram_visible_bit_ff) |-> !rd_strobe_out && !wr_strobe_out)
    else $error("strobe during hidden xram access");

  // Visible XRAM reads show on the bus.
  a_visible_strobe: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (use_xram_out && xram_visible_bit_ff && !external_move_instr_write_in) |-> rd_strobe_out && port0_bus_out)
    else $error("visible xram read not shown");

  // Visible XRAM writes show on the bus as well.
  a_visible_write: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (use_xram_out && xram_visible_bit_ff && external_move_instr_write_in)
    |-> wr_strobe_out && port0_bus_out)
    else $error("visible xram write not shown");

  // Outside the XRAM the visible bit changes nothing: unswapped reads always strobe.
  a_visible_ignored: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (external_move_instr_req_in && !use_xram_out && !swapped && !external_move_instr_write_in)
    |-> rd_strobe_out && port0_bus_out)
    else $error("external read without strobe");

  // Pointer moves at or above the base reach enabled XRAM.
  a_range_hit: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (external_move_instr_req_in && !external_move_instr_ri_in && !xram_disable_bit_ff && !swapped
     && pointer16_in >= xram_decode_pkg::XRAM_BASE) |-> use_xram_out)
    else $error("pointer move in range missed xram");

  // Indirect moves take their high byte from the page register.
  a_page_high: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (external_move_instr_req_in && external_move_instr_ri_in)
    |-> external_move_instr_addr_out == {xram_page_reg_ff, ri_low_in})
    else $error("indirect move address wrong");

  // Pointer moves below the range always go outside on the full bus.
  a_low_external: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (external_move_instr_req_in && !external_move_instr_ri_in && pointer16_in < xram_decode_pkg::XRAM_BASE)
    |-> !use_xram_out && port2_bus_out)
    else $error("low pointer move not external");

  // A disabled XRAM is never used.
  a_disabled_external: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    xram_disable_bit_ff |-> !use_xram_out)
    else $error("xram used while disabled");

  // Hidden XRAM drives the bus only while the pin is low.
  a_hidden_bus: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (use_xram_out && !xram_visible_bit_ff)
    |-> port0_bus_out == !external_access_pin_in)
    else $error("hidden xram port use wrong");

  // Indirect moves leave port 2 as ordinary I/O.
  a_ri_port2_io: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (external_move_instr_req_in && external_move_instr_ri_in) |-> !port2_bus_out)
    else $error("port 2 driven on ri move");

  // Indirect moves below the XRAM page go out on port 0.
  a_low_page_ext: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (external_move_instr_req_in && external_move_instr_ri_in && xram_page_reg_ff < xram_decode_pkg::XRAM_PAGE_BASE)
    |-> !use_xram_out && port0_bus_out)
    else $error("low page move not external");

  // Without an external move there is no XRAM data access.
  a_no_idle_xram: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !external_move_instr_req_in
    |-> !use_xram_out && !rd_strobe_out && !wr_strobe_out)
    else $error("data access without a move");

  // Programming mode writes the flash through its own strobe.
  a_prog_flash_wr: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (mode_prog && external_move_instr_req_in && external_move_instr_write_in)
    |-> flash_write_strobe_out && !wr_strobe_out)
    else $error("programming write not on flash strobe");

  // Programming mode fetches from XRAM at the top of code space.
  a_prog_xram_code: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (mode_prog && fetch_req_in && fetch_addr_in >= xram_decode_pkg::XRAM_BASE)
    |-> fetch_xram_out)
    else $error("programming fetch missed xram");

  // Programming mode fetches use the alternate code strobe.
  a_prog_alt_fetch: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (mode_prog && fetch_req_in && !fetch_boot_rom_out && !fetch_xram_out)
    |-> alt_code_strobe_out && !code_strobe_out)
    else $error("programming fetch on wrong strobe");

  // Swapped modes read data through the flash read pin.
  a_flash_read: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (swapped && external_move_instr_req_in && !external_move_instr_write_in)
    |-> flash_read_out && !rd_strobe_out)
    else $error("swapped read not on flash pin");

  // The boot flag takes the pin level seen on the first clock after reset.
  a_boot_capture: assert property (@(posedge core_clk_in)
    $rose(rst_n_in)
    |=> boot_mode_flag_ff == $past(boot_select_pin_in))
    else $error("boot flag not captured");

  // Bootstrap mode starts in the boot ROM.
  a_boot_entry: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (chipmode_out == xram_decode_pkg::MODE_BOOT && fetch_req_in
     && fetch_addr_in < xram_decode_pkg::EXT_CODE_BASE) |-> fetch_boot_rom_out)
    else $error("bootstrap fetch missed boot rom");

  // Low fetches go to the boot ROM whenever the flag is set.
  a_boot_rom_low: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (fetch_req_in && boot_mode_flag_ff && fetch_addr_in <= xram_decode_pkg::BOOT_ROM_TOP)
    |-> fetch_boot_rom_out && !code_strobe_out && !alt_code_strobe_out)
    else $error("low fetch missed boot rom");

  // The two control bits read back at their positions.
  a_system_control_reg_read: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (reg_rd_in && reg_addr_in == xram_decode_pkg::SYSTEM_CONTROL_REG_ADDR)
    |=> reg_rdata_out[xram_decode_pkg::XRAM_DIS_POS] == $past(xram_disable_bit_ff)
        && reg_rdata_out[xram_decode_pkg::XRAM_VIS_POS] == $past(xram_visible_bit_ff))
    else $error("control bits read back wrong");

  // Normal mode has no boot ROM and uses the plain code strobe.
  a_normal_fetch: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (chipmode_out == xram_decode_pkg::MODE_NORMAL && fetch_req_in)
    |-> !fetch_boot_rom_out && code_strobe_out)
    else $error("normal mode fetch routed wrong");

  // XRAM chipmode never writes the external data space.
  a_xram_no_write: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (chipmode_out == xram_decode_pkg::MODE_XRAM) |-> !wr_strobe_out && !flash_write_strobe_out)
    else $error("write strobe in xram chipmode");

endmodule : xram_external_move_instr_access_decode

/* design/xram_decode_pkg.sv */
package xram_decode_pkg;

  // System control register location and bit positions.
  localparam logic [7:0] SYSTEM_CONTROL_REG_ADDR = 8'hb1;
  localparam int XRAM_DIS_POS = 0;
  localparam int XRAM_VIS_POS = 1;
  localparam int MAP_SEL_POS = 4;
  localparam logic [7:0] SYSTEM_CONTROL_REG_RESET = 8'ha1;

  // Chipmode control register and its bit positions.
  localparam logic [7:0] CHIPMODE_ADDR = 8'hb2;
  localparam int SWAP_POS = 0;
  localparam int BOOT_FLAG_POS = 1;

  // Page register for 8-bit indirect moves.
  localparam logic [7:0] XRAM_PAGE_REG_REG_ADDR = 8'hb3;
  localparam logic [7:0] XRAM_PAGE_REG_RESET = 8'h00;

  // Address ranges.
  localparam logic [15:0] XRAM_BASE = 16'hf700;
  localparam logic [7:0] XRAM_PAGE_BASE = 8'hf7;
  localparam logic [15:0] BOOT_ROM_TOP = 16'h01ff;
  localparam logic [15:0] EXT_CODE_BASE = 16'h0200;

  // Chipmode encoding: boot flag, swap bit.
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_XRAM = 2'b01,
    MODE_BOOT = 2'b10,
    MODE_PROG = 2'b11
  } chipmode_t;

endpackage : xram_decode_pkg

/* tb/ext_mem_model.sv */
`timescale 1ns/1ps
// Far-side memory on the multiplexed bus, counting the cycles it would answer.
module ext_mem_model (
  // Clock.
  input wire logic clk_in,
  // Strobes seen on the bus.
  input wire logic rd_strobe_in,
  input wire logic wr_strobe_in,
  // Boot request from the bench.
  input wire logic boot_req_in,
  // Pin level and answered cycles.
  output logic boot_select_pin_out,
  output int access_count_out
);
  // The pin is a held level, so it is stable across the reset release edge.
  assign boot_select_pin_out = boot_req_in;
  // One count per strobed cycle, so a stuck strobe shows up as extra cycles.
  always_ff @(posedge clk_in) begin
    if (rd_strobe_in || wr_strobe_in) access_count_out <= access_count_out + 1;
  end
endmodule : ext_mem_model

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic core_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, ea = 0, boot_req = 0, pd = 0;
  logic req = 0, mw = 0, ri = 0, freq = 0, bsel, pm = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, low = 8'h00, rdata;
  logic [15:0] ptr = 16'h0000, faddr = 16'h0000, maddr;
  logic use_x, p0, p2, rds, wrs, frd, fwr, cs, acs, fboot, fx;
  logic [1:0] mode;
  logic [31:0] seed = 32'd71451;
  int err_count = 0, tests_run = 0, acc, acc0, n_exp = 0, dis, vis, page;
  ////////////////////////////////////////////////////////////////////////////////
  // Free-running 125 MHz clock.
  always #4 core_clk = ~core_clk;
  xram_external_move_instr_access_decode u_xram_external_move_instr_access_decode (.core_clk_in(core_clk), .rst_n_in(rst_n),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_rdata_out(rdata), .external_access_pin_in(ea), .boot_select_pin_in(bsel),
    .hw_powerdown_pin_in(pd), .external_move_instr_req_in(req), .external_move_instr_write_in(mw), .external_move_instr_ri_in(ri),
    .pointer16_in(ptr), .ri_low_in(low), .fetch_req_in(freq), .fetch_addr_in(faddr),
    .external_move_instr_addr_out(maddr), .use_xram_out(use_x), .port0_bus_out(p0), .port2_bus_out(p2),
    .rd_strobe_out(rds), .wr_strobe_out(wrs), .flash_read_out(frd),
    .flash_write_strobe_out(fwr), .code_strobe_out(cs), .alt_code_strobe_out(acs),
    .fetch_boot_rom_out(fboot), .fetch_xram_out(fx), .chipmode_out(mode));
  ext_mem_model u_ext_mem_model (.clk_in(core_clk), .rd_strobe_in(rds), .wr_strobe_in(wrs),
    .boot_req_in(boot_req), .boot_select_pin_out(bsel), .access_count_out(acc));
  ////////////////////////////////////////////////////////////////////////////////
  // Shift register for stimulus; a fixed start keeps runs repeatable.
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic give_verdict();
    if (err_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
  task automatic reset_dut(input logic b);
    boot_req <= b;
    rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
  endtask : reset_dut
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [7:0] a, input logic [7:0] exp, input string nm);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(nm, {8'h00, rdata}, {8'h00, exp});
  endtask : reg_read
  task automatic fetch(input logic [15:0] a);
    @(posedge core_clk);
    freq <= 1'b1;
    faddr <= a;
    #1;
  endtask : fetch
  // Reference decode of one move, held for exactly one sampled edge.
  task automatic external_move_instr(input logic w, input logic i, input logic [15:0] p, input logic dec);
    logic [15:0] a;
    logic xr;
    logic st;
    @(posedge core_clk);
    req <= 1'b1;
    mw <= w;
    ri <= i;
    ptr <= p;
    low <= p[7:0];
    #1;
    a = i ? {page[7:0], p[7:0]} : p;
    xr = !dis[0] && (i ? (page[7:0] >= 8'hf7) : (p >= 16'hf700));
    st = !xr || vis[0];
    if (dec) begin
      n_exp += st;
      chk("addr", maddr, a);
      chk("use_xram", use_x, xr);
      chk("rd", rds, !w && st);
      chk("wr", wrs, w && st);
      chk("port0", p0, st || !ea);
      chk("port2", p2, !i && (st || !ea));
    end else begin
      chk("flash_wr", fwr, w && pm);
      chk("flash_rd", frd, !w);
      chk("wr", wrs, 1'b0);
    end
    @(posedge core_clk);
    req <= 1'b0;
  endtask : external_move_instr
  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog sized well above the few hundred cycles the sequence needs.
  initial begin
    #200000;
    err_count++;
    give_verdict();
  end
  // Main sequence.
  initial begin
    reset_dut(1'b0);
    reg_read(8'hb1, 8'ha1, "system_control_reg");
    reg_read(8'h10, 8'h00, "unmapped");
    dis = 1;
    vis = 0;
    page = 0;
    acc0 = acc;
    for (int i = 0; i < 120; i++) begin
      seed = lfsr(seed);
      if (i == 40) begin
        reg_write(8'hb1, 8'h00);
        dis = 0;
      end
      if (i % 8 == 0) begin
        vis = seed[5];
        reg_write(8'hb1, {6'h00, seed[5], 1'b1});
        reg_read(8'hb1, {6'h08, vis[0], dis[0]}, "system_control_reg_rw");
      end
      if (i % 8 == 4) begin
        page = seed[9] ? seed[31:24] : 8'hf6 + seed[10];
        reg_write(8'hb3, page[7:0]);
        reg_read(8'hb3, page[7:0], "page");
      end
      ea <= seed[6];
      external_move_instr(seed[7], seed[8], (i % 3 == 0) ? 16'hf6ff + 16'(i % 2) : seed[31:16], 1'b1);
    end
    repeat (2) @(posedge core_clk);
    chk("bus_cycles", 16'(acc - acc0), 16'(n_exp));
    reset_dut(1'b1);
    #1 chk("mode_boot", mode, 2'b10);
    fetch(16'h01ff);
    chk("boot_rom", fboot, 1'b1);
    fetch(16'h0200);
    chk("boot_rom", fboot, 1'b0);
    reg_write(8'hb2, 8'h01);
    pm = 1;
    fetch(16'h0300);
    chk("mode_prog", mode, 2'b11);
    chk("alt_code", acs, 1'b1);
    fetch(16'hf800);
    chk("fetch_xram", fx, 1'b1);
    chk("alt_code_x", acs, 1'b0);
    external_move_instr(1'b1, 1'b0, 16'h1234, 1'b0);
    external_move_instr(1'b0, 1'b0, 16'hf800, 1'b0);
    reset_dut(1'b0);
    fetch(16'h0100);
    chk("normal_boot", fboot, 1'b0);
    chk("code_strobe", cs, 1'b1);
    reg_write(8'hb2, 8'h01);
    pm = 0;
    external_move_instr(1'b1, 1'b0, 16'h2000, 1'b0);
    chk("mode_xram", mode, 2'b01);
    boot_req <= 1'b1;
    pd <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1 chk("pd_boot", mode[1], 1'b1);
    give_verdict();
  end
endmodule : testbench
